// >>> rtl/sic_ctrl.sv
// Our own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
module sic_ctrl (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // Two-wire pins
  input  wire logic        sda_i,
  input  wire logic        scl_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             scl_o,
  output logic             scl_oe_o,
  // Interrupt
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                         ack_q;
  logic [31:0]                  dat_q;
  logic                         chan_active_flag_q;
  logic                         serial_out_enable_q;
  logic                         data_out_level_q;
  logic                         clock_out_level_q;
  sic_pkg::sic_mode_s           mode_q;
  logic [sic_pkg::IRQ_W-1:0]    irq_flag_q;
  logic [sic_pkg::IRQ_W-1:0]    irq_mask_q;
  logic                         irq_q;
  sic_pkg::sic_eng_e            state_q;
  logic [sic_pkg::CNT_W-1:0]    cnt_q;
  logic [3:0]                   bit_q;
  logic [7:0]                   shift_q;
  logic                         nack_q;
  sic_pkg::sic_line_s           eng_q;
  sic_pkg::sic_line_s           pin_q;
  sic_pkg::sic_line_s           oe_q;
  logic                         req;
  logic                         wr;
  logic                         wr_b0;
  logic                         chan_stop_trigger;
  logic                         chan_start_trigger;
  logic                         mode_on;
  logic                         xfer_go;
  logic                         half_done;
  logic                         bit_end;
  logic                         frame_end;
  logic                         err_evt;
  logic [sic_pkg::IRQ_W-1:0]    irq_set;
  logic [7:0]                   shift_nx;
  sic_pkg::sic_line_s           pin_d;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req   = cyc_i & stb_i & ~ack_q;
  assign wr    = req & we_i;
  assign wr_b0 = wr & sel_i[0];
  assign chan_stop_trigger  = wr_b0 & (adr_i == sic_pkg::ADDR_STOP)
                              & dat_i[sic_pkg::CH0_BIT];
  assign chan_start_trigger = wr_b0 & (adr_i == sic_pkg::ADDR_START)
                              & dat_i[sic_pkg::CH0_BIT];
  assign mode_on = mode_q.tx_enable_bit | mode_q.rx_enable_bit;
  assign xfer_go = wr_b0 & (adr_i == sic_pkg::ADDR_DATA) & chan_active_flag_q
                   & mode_on & (state_q == sic_pkg::ENG_IDLE) & ~chan_stop_trigger;

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req & ~we_i) begin
      dat_q <= 32'h0000_0000;
      case (adr_i)
        sic_pkg::ADDR_SOE:    dat_q[sic_pkg::CH0_BIT] <= serial_out_enable_q;
        sic_pkg::ADDR_SO:     dat_q[sic_pkg::CH0_BIT] <= data_out_level_q;
        sic_pkg::ADDR_CKO:    dat_q[sic_pkg::CH0_BIT] <= clock_out_level_q;
        sic_pkg::ADDR_MODE:   dat_q[7:0] <= mode_q;
        sic_pkg::ADDR_IRQ_ST: dat_q[sic_pkg::IRQ_W-1:0] <= irq_flag_q;
        sic_pkg::ADDR_IRQ_MK: dat_q[sic_pkg::IRQ_W-1:0] <= irq_mask_q;
        sic_pkg::ADDR_DATA:   dat_q[7:0] <= shift_q;
        sic_pkg::ADDR_STATUS: begin
          dat_q[sic_pkg::ST_ACT_BIT]  <= chan_active_flag_q;
          dat_q[sic_pkg::ST_BUSY_BIT] <= (state_q != sic_pkg::ENG_IDLE);
          dat_q[sic_pkg::ST_NACK_BIT] <= nack_q;
        end
        default: dat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------
  // Channel active flag
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_active_flag_q <= 1'b0;
    end else if (chan_stop_trigger) begin
      chan_active_flag_q <= 1'b0;
    end else if (chan_start_trigger) begin
      chan_active_flag_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      serial_out_enable_q <= sic_pkg::SOE_RST;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_SOE)) begin
      serial_out_enable_q <= dat_i[sic_pkg::CH0_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_out_level_q <= sic_pkg::SO_RST;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_SO)) begin
      data_out_level_q <= dat_i[sic_pkg::CH0_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_out_level_q <= sic_pkg::CKO_RST;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_CKO)) begin
      clock_out_level_q <= dat_i[sic_pkg::CH0_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= sic_pkg::MODE_RST;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_MODE)) begin
      mode_q <= dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask_q <= sic_pkg::MASK_RST;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_IRQ_MK)) begin
      irq_mask_q <= dat_i[sic_pkg::IRQ_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  assign half_done = (cnt_q == sic_pkg::CNT_ZERO);
  assign shift_nx  = {shift_q[6:0], sda_i};
  assign bit_end   = (state_q == sic_pkg::ENG_HIGH) & half_done & scl_i
                     & ~chan_stop_trigger & ~chan_start_trigger;
  assign frame_end = bit_end & (bit_q == sic_pkg::ACK_BIT);
  assign err_evt   = frame_end & mode_q.tx_enable_bit & sda_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_q <= 8'h00;
    end else if (xfer_go) begin
      shift_q <= dat_i[7:0];
    end else if (bit_end & (bit_q != sic_pkg::ACK_BIT)) begin
      shift_q <= shift_nx;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nack_q <= 1'b0;
    end else if (frame_end) begin
      nack_q <= sda_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sic_pkg::ENG_IDLE;
      cnt_q   <= sic_pkg::CNT_ZERO;
      bit_q   <= sic_pkg::BIT_ZERO;
      eng_q   <= '{scl: sic_pkg::CKO_RST, sda: sic_pkg::SO_RST};
    end else if (chan_stop_trigger) begin
      state_q <= sic_pkg::ENG_IDLE;
    end else if (chan_start_trigger) begin
      state_q <= sic_pkg::ENG_IDLE;
      eng_q   <= '{scl: clock_out_level_q, sda: data_out_level_q};
    end else begin
      case (state_q)
        sic_pkg::ENG_IDLE: begin
          if (xfer_go) begin
            state_q   <= sic_pkg::ENG_LOW;
            cnt_q     <= sic_pkg::HALF_CNT;
            bit_q     <= sic_pkg::BIT_ZERO;
            eng_q.scl <= 1'b0;
            eng_q.sda <= mode_q.tx_enable_bit ? dat_i[7] : 1'b1;
          end else if (~chan_active_flag_q) begin
            // Stopped channel mirrors the level bits, no glitch on enable
            eng_q <= '{scl: clock_out_level_q, sda: data_out_level_q};
          end
        end
        sic_pkg::ENG_LOW: begin
          if (half_done) begin
            state_q   <= sic_pkg::ENG_HIGH;
            cnt_q     <= sic_pkg::HALF_CNT;
            eng_q.scl <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 7'h01;
          end
        end
        sic_pkg::ENG_HIGH: begin
          if (~scl_i) begin
            cnt_q <= cnt_q;
          end else if (~half_done) begin
            cnt_q <= cnt_q - 7'h01;
          end else if (bit_q == sic_pkg::ACK_BIT) begin
            state_q   <= sic_pkg::ENG_IDLE;
            eng_q.scl <= 1'b0;
            eng_q.sda <= 1'b1;
          end else begin
            state_q   <= sic_pkg::ENG_LOW;
            cnt_q     <= sic_pkg::HALF_CNT;
            bit_q     <= bit_q + 4'h1;
            eng_q.scl <= 1'b0;
            if (bit_q == sic_pkg::LAST_BIT) begin
              eng_q.sda <= ~(mode_q.rx_enable_bit & ~mode_q.tx_enable_bit);
            end else begin
              eng_q.sda <= mode_q.tx_enable_bit ? shift_nx[7] : 1'b1;
            end
          end
        end
        default: state_q <= sic_pkg::ENG_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  always_comb begin
    irq_set = '0;
    if (err_evt & mode_q.error_irq_select) begin
      irq_set[sic_pkg::IRQ_ERR] = 1'b1;
    end else begin
      irq_set[sic_pkg::IRQ_DONE] = frame_end;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_flag_q <= '0;
    end else if (wr_b0 & (adr_i == sic_pkg::ADDR_IRQ_ST)) begin
      irq_flag_q <= (irq_flag_q & ~dat_i[sic_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_flag_q <= irq_flag_q | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_flag_q & ~irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_comb begin
    if (serial_out_enable_q) begin
      pin_d = eng_q;
    end else begin
      pin_d = '{scl: clock_out_level_q, sda: data_out_level_q};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_q <= '{scl: sic_pkg::CKO_RST, sda: sic_pkg::SO_RST};
    end else begin
      pin_q <= pin_d;
    end
  end

  // Open drain: enable only while the line is pulled low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= '{scl: ~sic_pkg::CKO_RST, sda: ~sic_pkg::SO_RST};
    end else begin
      oe_q <= '{scl: ~pin_d.scl, sda: ~pin_d.sda};
    end
  end

  assign sda_o    = pin_q.sda;
  assign sda_oe_o = oe_q.sda;
  assign scl_o    = pin_q.scl;
  assign scl_oe_o = oe_q.scl;

endmodule

// >>> pkg/sic_pkg.sv
// Overview of operation
// - Writing one to stop trigger clears active flag and halts the channel.
// - Serial engine drives the pins only while serial output enable is one.
// - Data output level bit sets the data output to one or zero.
// - Clock output level bit sets the clock output to one or zero.
// - Transmit/receive enable pair selects disabled, receive, transmit or both.
// - Error select zero gives transfer interrupt; one gives error interrupt instead on a transmit NACK.
// - Writing one to start trigger sets active flag and enters wait state.
// - Transfer interrupt flag reads one once raised, zero when nothing pending.
// - Interrupt mask zero allows the transfer interrupt, one blocks it.
package sic_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SCL_HALF_NS   = 1300;
  localparam int unsigned HALF_CYC      = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 7;
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STOP   = 8'h00;
  localparam logic [7:0] ADDR_START  = 8'h04;
  localparam logic [7:0] ADDR_SOE    = 8'h08;
  localparam logic [7:0] ADDR_SO     = 8'h0C;
  localparam logic [7:0] ADDR_CKO    = 8'h10;
  localparam logic [7:0] ADDR_MODE   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MK = 8'h1C;
  localparam logic [7:0] ADDR_DATA   = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CH0_BIT     = 0;
  localparam int unsigned IRQ_DONE    = 0;
  localparam int unsigned IRQ_ERR     = 1;
  localparam int unsigned IRQ_W       = 2;
  localparam int unsigned ST_ACT_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT = 1;
  localparam int unsigned ST_NACK_BIT = 2;
  localparam logic       SO_RST       = 1'h1;
  localparam logic       CKO_RST      = 1'h1;
  localparam logic       SOE_RST      = 1'h0;
  localparam logic [7:0] MODE_RST     = 8'h00;
  localparam logic [IRQ_W-1:0] MASK_RST = 2'h3;
  localparam logic [3:0] ACK_BIT      = 4'h8;
  localparam logic [3:0] BIT_ZERO     = 4'h0;
  localparam logic [3:0] LAST_BIT     = 4'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic data_phase_sel;
    logic clock_phase_sel;
    logic rsvd;
    logic error_irq_select;
    logic parity_ctrl_hi;
    logic parity_ctrl_lo;
  } sic_mode_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } sic_line_s;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_LOW,
    ENG_HIGH
  } sic_eng_e;

endpackage

// >>> test/sic_eeprom_model.sv
`timescale 1ns/1ps
module sic_eeprom_model (
  // Bus lines
  input  wire logic scl_i,
  input  wire logic sda_i,
  // Control
  input  wire logic nack_i,
  output logic      sda_oe_o
);
  int rises;
  initial begin
    rises = 0;
    sda_oe_o = 1'b0;
  end
  // Start condition restarts the bit count; a clock fall in the same step wins
  always @(negedge sda_i) begin
    #1;
    if (scl_i === 1'b1) begin
      rises = 0;
    end
  end
  always @(posedge scl_i) begin
    rises = rises + 1;
  end
  // Pull data low for the acknowledge slot
  always @(negedge scl_i) begin
    sda_oe_o = (rises == 8) && !nack_i;
    if (rises >= 9) begin
      rises = 0;
    end
  end
endmodule

// >>> test/sic_ctrl_checker.sv
`timescale 1ns/1ps
module sic_ctrl_checker (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins and interrupt
  input wire logic        sda_i,
  input wire logic        scl_i,
  input wire logic        sda_o,
  input wire logic        sda_oe_o,
  input wire logic        scl_o,
  input wire logic        scl_oe_o,
  input wire logic        irq_o
);
  logic req;
  logic wr;
  logic soe_q;
  logic act_q;
  assign req = cyc_i & stb_i & ~ack_o;
  assign wr  = req & we_i & sel_i[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soe_q <= 1'b0;
    end else if (wr && adr_i == sic_pkg::ADDR_SOE) begin
      soe_q <= dat_i[0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || (wr && adr_i == sic_pkg::ADDR_STOP && dat_i[0])) begin
      act_q <= 1'b0;
    end else if (wr && adr_i == sic_pkg::ADDR_START && dat_i[0]) begin
      act_q <= 1'b1;
    end
  end
  a_ack_follows: assert property (req |=> ack_o)
    else $error("request not answered");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_sda_drain: assert property (sda_oe_o == !sda_o)
    else $error("data enable not inverse of level");
  a_scl_drain: assert property (scl_oe_o == !scl_o)
    else $error("clock enable not inverse of level");
  a_sda_follow: assert property (
    wr && adr_i == sic_pkg::ADDR_SO && !soe_q |=> ##1 sda_o == $past(dat_i[0], 2))
    else $error("data pin misses level bit");
  a_scl_follow: assert property (
    wr && adr_i == sic_pkg::ADDR_CKO && !soe_q |=> ##1 scl_o == $past(dat_i[0], 2))
    else $error("clock pin misses level bit");
  a_irq_masked: assert property (
    wr && adr_i == sic_pkg::ADDR_IRQ_MK && dat_i[1:0] == 2'h3 |=> ##1 !irq_o)
    else $error("irq high while masked");
  a_stat_active: assert property (
    req && !we_i && adr_i == sic_pkg::ADDR_STATUS |=> dat_o[0] == act_q)
    else $error("active flag wrong");
  a_unmapped_zero: assert property (
    req && !we_i && adr_i > sic_pkg::ADDR_STATUS |=> dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, irq_o, nack;
  logic        sda_o, sda_oe_o, scl_o, scl_oe_o, m_oe, sda_w, scl_w;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rv;
  int          err_count, n_checks, cyc_n;
  logic [7:0]  ra [7] = '{sic_pkg::ADDR_SOE, sic_pkg::ADDR_SO, sic_pkg::ADDR_CKO,
    sic_pkg::ADDR_MODE, sic_pkg::ADDR_IRQ_ST, sic_pkg::ADDR_IRQ_MK, sic_pkg::ADDR_STATUS};
  logic [31:0] rx [7] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h0, 32'h3, 32'h0};
  assign sda_w = ~(sda_oe_o | m_oe);
  assign scl_w = ~scl_oe_o;
  sic_ctrl i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .sda_i(sda_w), .scl_i(scl_w), .sda_o, .sda_oe_o, .scl_o, .scl_oe_o, .irq_o);
  sic_eeprom_model i_mem (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack), .sda_oe_o(m_oe));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rv = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  task automatic pin(input logic [1:0] e);
    @(posedge clk_i);
    chk({30'h0, scl_o, sda_o}, {30'h0, e});
  endtask
  task automatic irqc(input logic e);
    @(posedge clk_i);
    chk({31'h0, irq_o}, {31'h0, e});
  endtask
  task automatic frame(input logic [7:0] d);
    bus(1'b1, sic_pkg::ADDR_DATA, {24'h0, d});
    repeat (2) @(posedge clk_i);
    chk({31'h0, scl_o}, 32'h0);
    for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    chk({31'h0, irq_o}, 32'h1);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    {rst_i, cyc_i, stb_i, we_i, nack} = 5'h10;
    adr_i = 8'h00;
    sel_i = 4'hF;
    dat_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      rdc(ra[i], rx[i]);
    end
    bus(1'b1, 8'h40, 32'hFF);
    rdc(8'h40, 32'h0);
    $display("test reset done");
    bus(1'b1, sic_pkg::ADDR_STOP, 32'h1);
    bus(1'b1, sic_pkg::ADDR_SOE, 32'h0);
    bus(1'b1, sic_pkg::ADDR_SO, 32'h0);
    pin(2'h2);
    bus(1'b1, sic_pkg::ADDR_CKO, 32'h0);
    pin(2'h0);
    bus(1'b1, sic_pkg::ADDR_CKO, 32'h1);
    bus(1'b1, sic_pkg::ADDR_SO, 32'h1);
    pin(2'h3);
    bus(1'b1, sic_pkg::ADDR_SO, 32'h0);
    pin(2'h2);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, sic_pkg::ADDR_MODE, 32'(i * 64));
      rdc(sic_pkg::ADDR_MODE, 32'(i * 64));
    end
    bus(1'b1, sic_pkg::ADDR_MODE, 32'h80);
    bus(1'b1, sic_pkg::ADDR_SOE, 32'h1);
    bus(1'b1, sic_pkg::ADDR_START, 32'h1);
    bus(1'b1, sic_pkg::ADDR_STOP, 32'h0);
    rdc(sic_pkg::ADDR_STATUS, 32'h1);
    bus(1'b1, sic_pkg::ADDR_IRQ_ST, 32'h3);
    bus(1'b1, sic_pkg::ADDR_IRQ_MK, 32'h0);
    $display("test start done");
    frame(8'hA5);
    irqc(1'b1);
    rdc(sic_pkg::ADDR_IRQ_ST, 32'h1);
    rdc(sic_pkg::ADDR_STATUS, 32'h1);
    bus(1'b1, sic_pkg::ADDR_IRQ_MK, 32'h1);
    irqc(1'b0);
    bus(1'b1, sic_pkg::ADDR_IRQ_MK, 32'h0);
    irqc(1'b1);
    bus(1'b1, sic_pkg::ADDR_IRQ_ST, 32'h1);
    irqc(1'b0);
    rdc(sic_pkg::ADDR_IRQ_ST, 32'h0);
    $display("test irq done");
    nack <= 1'b1;
    bus(1'b1, sic_pkg::ADDR_MODE, 32'h84);
    frame(8'h3C);
    rdc(sic_pkg::ADDR_IRQ_ST, 32'h2);
    rdc(sic_pkg::ADDR_STATUS, 32'h5);
    bus(1'b1, sic_pkg::ADDR_IRQ_MK, 32'h3);
    irqc(1'b0);
    bus(1'b1, sic_pkg::ADDR_IRQ_MK, 32'h0);
    bus(1'b1, sic_pkg::ADDR_IRQ_ST, 32'h3);
    bus(1'b1, sic_pkg::ADDR_MODE, 32'h80);
    frame(8'hC3);
    rdc(sic_pkg::ADDR_IRQ_ST, 32'h1);
    $display("test error select done");
    bus(1'b1, sic_pkg::ADDR_IRQ_ST, 32'h3);
    bus(1'b1, sic_pkg::ADDR_MODE, 32'h40);
    frame(8'h00);
    rdc(sic_pkg::ADDR_DATA, 32'hFF);
    rdc(sic_pkg::ADDR_STATUS, 32'h1);
    bus(1'b1, sic_pkg::ADDR_MODE, 32'h00);
    bus(1'b1, sic_pkg::ADDR_DATA, 32'h5A);
    rdc(sic_pkg::ADDR_STATUS, 32'h1);
    rdc(sic_pkg::ADDR_DATA, 32'hFF);
    $display("test mode done");
    bus(1'b1, sic_pkg::ADDR_STOP, 32'h1);
    bus(1'b1, sic_pkg::ADDR_SOE, 32'h0);
    bus(1'b1, sic_pkg::ADDR_SO, 32'h0);
    pin(2'h2);
    bus(1'b1, sic_pkg::ADDR_SO, 32'h1);
    pin(2'h3);
    rdc(sic_pkg::ADDR_STATUS, 32'h0);
    $display("test stop done");
    final_report();
  end
endmodule
bind sic_ctrl sic_ctrl_checker u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
  .sel_i, .dat_i, .dat_o, .ack_o, .sda_i, .scl_i, .sda_o, .sda_oe_o, .scl_o, .scl_oe_o,
  .irq_o);
